// ==== rtl/aic_pkg.sv ====
`default_nettype none
package aic_pkg;
   // ****************************************
   // sizes
   // ****************************************
   localparam int NUM_AXES = 4;
   localparam int ERR_W    = 18;
   localparam int EVT_W    = 20;
   localparam int EN_W     = 19;
   localparam int DATA_W   = 32;
   localparam int CODE_W   = 8;

   // ****************************************
   // command codes written by the cpu
   // ****************************************
   localparam logic [CODE_W-1:0] CMD_RD_ERR = 8'hF2;
   localparam logic [CODE_W-1:0] CMD_RD_EVT = 8'hF3;
   localparam logic [CODE_W-1:0] CMD_WR_EN  = 8'hAC;

   // ****************************************
   // field positions and reset values
   // ****************************************
   localparam int EN_BIT_DR  = 17;
   localparam int EN_BIT_CSA = 18;
   localparam logic [ERR_W-1:0]  ERR_UNDEF_MASK  = 18'h00800;
   localparam logic [ERR_W-1:0]  ERR_NOSTOP_MASK = 18'h30000;
   localparam logic [ERR_W-1:0]  ERR_RESET       = 18'h00000;
   localparam logic [EVT_W-1:0]  EVT_RESET       = 20'h00000;
   localparam logic [EN_W-1:0]   EN_RESET        = 19'h00000;
   localparam logic [DATA_W-1:0] RD_RESET        = 32'h00000000;

   // ****************************************
   // carriers
   // ****************************************
   // packed msb first, so each field lands on its cause bit
   typedef struct packed {
      logic       pulser_err;
      logic       encoder_err;
      logic       range_ovf;
      logic       pulser_ovf;
      logic       interp_peer;
      logic       data_err;
      logic       undef;
      logic       slowdown;
      logic       emergency;
      logic       sync_stop;
      logic       alarm;
      logic       neg_end_limit;
      logic       pos_end_limit;
      logic [4:0] cmp_stop;
   } aic_err_src_t;

   typedef struct packed {
      logic       sync_start;
      logic       manual_dir_neg_chg;
      logic       manual_dir_pos_chg;
      logic       slowdown_on;
      logic       origin_latch;
      logic       latch;
      logic       counter_clear;
      logic [4:0] cmp_met;
      logic       decel_end;
      logic       decel_start;
      logic       accel_end;
      logic       accel_start;
      logic       cmp5_pre_free;
      logic       pre2_free;
      logic       next_start;
      logic       auto_stop;
   } aic_evt_src_t;

   typedef struct packed {
      logic              valid;
      logic [1:0]        axis;
      logic [CODE_W-1:0] code;
      logic [DATA_W-1:0] data;
   } aic_cmd_t;

   typedef struct packed {
      logic stop_int;
      logic err_int;
      logic evt_int;
   } aic_msts_t;
endpackage
`default_nettype wire

// ==== rtl/aic_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module aic_top
   import aic_pkg::*;
(
   // clock and reset
   input  wire logic                          CLK,
   input  wire logic                          RST_B,
   // cpu command and buffer
   input  wire aic_cmd_t                      CMD,
   output var  logic [DATA_W-1:0]             RD_DATA,
   output var  logic                          RD_VALID,
   // cause sources from the motion engine
   input  wire aic_err_src_t [NUM_AXES-1:0]   ERR_SRC,
   input  wire aic_evt_src_t [NUM_AXES-1:0]   EVT_SRC,
   input  wire logic [NUM_AXES-1:0]           STOP_DONE,
   input  wire logic [NUM_AXES-1:0]           PRE_PENDING,
   input  wire logic [NUM_AXES-1:0]           START_CMD_RUN,
   input  wire logic [NUM_AXES-1:0]           MSTS_RD,
   // configuration
   input  wire logic [NUM_AXES-1:0]           STOP_INT_EN,
   input  wire logic [NUM_AXES-1:0]           STOP_SUPPRESS,
   input  wire logic                          INT_MASK,
   // status and interrupt
   output var  aic_msts_t [NUM_AXES-1:0]      MSTS,
   output var  logic [NUM_AXES-1:0]           STOP_REQ,
   output var  logic                          INT_N
);

   // ****************************************
   // enable to cause bit mapping
   // ****************************************
   // both direction changes share one enable, sync start sits one up
   function automatic logic [EVT_W-1:0] en_map(input logic [EN_W-1:0] en);
      en_map = {en[EN_BIT_CSA], en[EN_BIT_DR], en[EN_BIT_DR:0]};
   endfunction

   logic [NUM_AXES-1:0]   pend;
   logic [ERR_W-1:0]      err_all [NUM_AXES];
   logic [EVT_W-1:0]      evt_all [NUM_AXES];

   // ****************************************
   // per axis cause registers
   // ****************************************
   for (genvar a = 0; a < NUM_AXES; a++) begin : g_axis
      logic             hit;
      logic             rd_err;
      logic             rd_evt;
      logic [ERR_W-1:0] err_q;
      logic [ERR_W-1:0] err_d;
      logic [EVT_W-1:0] evt_q;
      logic [EVT_W-1:0] evt_d;
      logic [EN_W-1:0]  en_q;
      logic             seni_q;
      logic             seni_set;

      assign hit    = CMD.valid && (CMD.axis == 2'(a));
      assign rd_err = hit && (CMD.code == CMD_RD_ERR);
      assign rd_evt = hit && (CMD.code == CMD_RD_EVT);

      // set wins over the read clear, so a same-cycle cause survives
      always_comb begin
         err_d = (err_q & {ERR_W{!rd_err}}) | ERR_SRC[a];
         err_d = err_d & ~ERR_UNDEF_MASK;
      end

      always_comb begin
         evt_d = (evt_q & {EVT_W{!rd_evt}}) | (EVT_SRC[a] & en_map(en_q));
      end

      always_ff @(posedge CLK or negedge RST_B) begin
         if (!RST_B) begin
            err_q <= ERR_RESET;
         end else begin
            err_q <= err_d;
         end
      end

      always_ff @(posedge CLK or negedge RST_B) begin
         if (!RST_B) begin
            evt_q <= EVT_RESET;
         end else begin
            evt_q <= evt_d;
         end
      end

      always_ff @(posedge CLK or negedge RST_B) begin
         if (!RST_B) begin
            en_q <= EN_RESET;
         end else if (hit && (CMD.code == CMD_WR_EN)) begin
            en_q <= CMD.data[EN_W-1:0];
         end
      end

      // a start command run has nothing queued, so it is never suppressed
      assign seni_set = STOP_DONE[a] && STOP_INT_EN[a]
                        && (!STOP_SUPPRESS[a] || START_CMD_RUN[a] || !PRE_PENDING[a]);

      always_ff @(posedge CLK or negedge RST_B) begin
         if (!RST_B) begin
            seni_q <= 1'b0;
         end else begin
            seni_q <= seni_set || (seni_q && !MSTS_RD[a]);
         end
      end

      always_ff @(posedge CLK or negedge RST_B) begin
         if (!RST_B) begin
            MSTS[a]     <= '0;
            STOP_REQ[a] <= 1'b0;
         end else begin
            MSTS[a]     <= '{stop_int: seni_q, err_int: |err_q, evt_int: |evt_q};
            STOP_REQ[a] <= |(ERR_SRC[a] & ~ERR_NOSTOP_MASK & ~ERR_UNDEF_MASK);
         end
      end

      // an enable withdrawn later also withdraws a pending event
      assign pend[a]    = (|err_q) || (|(evt_q & en_map(en_q))) || seni_q;
      assign err_all[a] = err_q;
      assign evt_all[a] = evt_q;
   end

   // ****************************************
   // shared interrupt output
   // ****************************************
   // mask only gates the pin; causes keep collecting underneath
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         INT_N <= 1'b1;
      end else begin
         INT_N <= !((|pend) && !INT_MASK);
      end
   end

   // ****************************************
   // read buffer
   // ****************************************
   // the buffer shows the value before the clear takes effect
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         RD_DATA  <= RD_RESET;
         RD_VALID <= 1'b0;
      end else begin
         RD_VALID <= CMD.valid && ((CMD.code == CMD_RD_ERR) || (CMD.code == CMD_RD_EVT));
         if (CMD.valid && (CMD.code == CMD_RD_ERR)) begin
            RD_DATA <= {{(DATA_W-ERR_W){1'b0}}, err_all[CMD.axis]};
         end else if (CMD.valid && (CMD.code == CMD_RD_EVT)) begin
            RD_DATA <= {{(DATA_W-EVT_W){1'b0}}, evt_all[CMD.axis]};
         end
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);

   a_err_bit_set: assert property (
      (ERR_SRC[0] != '0) |=>
      ((g_axis[0].err_q & $past(ERR_SRC[0]) & ~ERR_UNDEF_MASK)
       == ($past(ERR_SRC[0]) & ~ERR_UNDEF_MASK)))
      else $error("error cause bit not set");

   a_err_undef_zero: assert property (
      ERR_SRC[1].undef |=> !g_axis[1].err_q[11] ##1 !RD_DATA[11] || !RD_VALID)
      else $error("error bit 11 not zero");

   a_err_read_clear: assert property (
      (CMD.valid && CMD.axis == 2'd0 && CMD.code == CMD_RD_ERR
       && ERR_SRC[0] == '0) |=> (g_axis[0].err_q == '0) && RD_VALID)
      else $error("error cause not cleared by read");

   a_evt_gated: assert property (
      (!g_axis[0].en_q[0] && !g_axis[0].evt_q[0]) |=> !g_axis[0].evt_q[0])
      else $error("disabled event was recorded");

   a_dir_neg_en17: assert property (
      (EVT_SRC[2].manual_dir_neg_chg && g_axis[2].en_q[17]) |=> g_axis[2].evt_q[18])
      else $error("negative direction change not at bit 18");

   a_sync_start_pos: assert property (
      (EVT_SRC[3].sync_start && g_axis[3].en_q[18]) |=> g_axis[3].evt_q[19])
      else $error("sync start not at bit 19");

   a_err_int_low: assert property (
      ((|g_axis[1].err_q) && !INT_MASK) |=> !INT_N)
      else $error("error cause did not pull interrupt low");

   a_mask_high: assert property (
      INT_MASK |=> INT_N)
      else $error("masked interrupt went low");

   a_stop_suppress: assert property (
      (STOP_DONE[1] && STOP_INT_EN[1] && STOP_SUPPRESS[1] && PRE_PENDING[1]
       && !START_CMD_RUN[1] && !g_axis[1].seni_q) |=> !g_axis[1].seni_q)
      else $error("stop interrupt not suppressed");

   a_start_cmd_stop: assert property (
      (STOP_DONE[2] && STOP_INT_EN[2] && START_CMD_RUN[2])
      |=> g_axis[2].seni_q ##1 MSTS[2].stop_int)
      else $error("start command stop interrupt missing");

   a_no_stop_err: assert property (
      ((ERR_SRC[2] & ~ERR_NOSTOP_MASK) == '0) |=> !STOP_REQ[2])
      else $error("encoder or pulser error stopped axis");

   a_all_clear_high: assert property (
      (pend == '0) |=> INT_N)
      else $error("interrupt low without a cause");

   a_cmp_stop_bits: assert property (
      (ERR_SRC[0].cmp_stop != '0) |=>
      ((g_axis[0].err_q[4:0] & $past(ERR_SRC[0].cmp_stop)) == $past(ERR_SRC[0].cmp_stop)))
      else $error("comparator stop bits not set");

   a_pos_limit_bit: assert property (
      ERR_SRC[2].pos_end_limit |=> g_axis[2].err_q[5])
      else $error("positive end limit bit not set");

   a_neg_limit_bit: assert property (
      ERR_SRC[2].neg_end_limit |=> g_axis[2].err_q[6])
      else $error("negative end limit bit not set");

   a_alarm_bit: assert property (
      ERR_SRC[1].alarm |=> g_axis[1].err_q[7])
      else $error("alarm stop bit not set");

   a_stop_input_bits: assert property (
      (ERR_SRC[0].sync_stop && ERR_SRC[0].emergency) |=> (g_axis[0].err_q[9:8] == 2'h3))
      else $error("sync or emergency stop bit not set");

   a_slowdown_stop_bit: assert property (
      ERR_SRC[0].slowdown |=> g_axis[0].err_q[10])
      else $error("slowdown stop bit not set");

   a_data_err_bit: assert property (
      ERR_SRC[0].data_err |=> g_axis[0].err_q[12])
      else $error("operation data error bit not set");

   a_interp_peer_bit: assert property (
      ERR_SRC[0].interp_peer |=> g_axis[0].err_q[13])
      else $error("interpolation peer stop bit not set");

   a_pulser_ovf_bit: assert property (
      ERR_SRC[2].pulser_ovf |=> g_axis[2].err_q[14])
      else $error("pulser overflow bit not set");

   a_range_ovf_bit: assert property (
      ERR_SRC[2].range_ovf |=> g_axis[2].err_q[15])
      else $error("out of range count bit not set");

   a_input_err_bits: assert property (
      (ERR_SRC[0].encoder_err && ERR_SRC[0].pulser_err) |=> (g_axis[0].err_q[17:16] == 2'h3))
      else $error("encoder or pulser error bit not set");

   a_auto_stop_evt: assert property (
      (EVT_SRC[0].auto_stop && g_axis[0].en_q[0]) |=> g_axis[0].evt_q[0])
      else $error("automatic stop event not at bit 0");

   a_next_start_evt: assert property (
      (EVT_SRC[0].next_start && g_axis[0].en_q[1]) |=> g_axis[0].evt_q[1])
      else $error("next start event not at bit 1");

   a_pre_free_evt: assert property (
      (EVT_SRC[0].pre2_free && g_axis[0].en_q[2]) |=> g_axis[0].evt_q[2])
      else $error("pre-register free event not at bit 2");

   a_cmp5_pre_evt: assert property (
      (EVT_SRC[0].cmp5_pre_free && g_axis[0].en_q[3]) |=> g_axis[0].evt_q[3])
      else $error("comparator five pre-register event not at bit 3");

   a_accel_start_evt: assert property (
      (EVT_SRC[2].accel_start && g_axis[2].en_q[4]) |=> g_axis[2].evt_q[4])
      else $error("acceleration start event not at bit 4");

   a_decel_end_evt: assert property (
      (EVT_SRC[2].decel_end && g_axis[2].en_q[7]) |=> g_axis[2].evt_q[7])
      else $error("deceleration end event not at bit 7");

   a_cmp_met_evt: assert property (
      ((EVT_SRC[0].cmp_met & g_axis[0].en_q[12:8]) != '0) |=>
      ((g_axis[0].evt_q[12:8] & $past(EVT_SRC[0].cmp_met & g_axis[0].en_q[12:8]))
       == $past(EVT_SRC[0].cmp_met & g_axis[0].en_q[12:8])))
      else $error("comparator met events not at bits 8 to 12");

   a_counter_clear_evt: assert property (
      (EVT_SRC[1].counter_clear && g_axis[1].en_q[13]) |=> g_axis[1].evt_q[13])
      else $error("counter clear event not at bit 13");

   a_origin_latch_evt: assert property (
      (EVT_SRC[1].origin_latch && g_axis[1].en_q[15]) |=> g_axis[1].evt_q[15])
      else $error("origin latch event not at bit 15");

   a_slowdown_on_evt: assert property (
      (EVT_SRC[3].slowdown_on && g_axis[3].en_q[16]) |=> g_axis[3].evt_q[16])
      else $error("slowdown event not at bit 16");

   a_dir_pos_en17: assert property (
      (EVT_SRC[2].manual_dir_pos_chg && g_axis[2].en_q[17]) |=> g_axis[2].evt_q[17])
      else $error("positive direction change not at bit 17");

   a_sync_start_gated: assert property (
      (!g_axis[3].en_q[18] && !g_axis[3].evt_q[19]) |=> !g_axis[3].evt_q[19])
      else $error("disabled sync start was recorded");

   a_err_set_wins: assert property (
      (CMD.valid && CMD.axis == 2'h0 && CMD.code == CMD_RD_ERR && ERR_SRC[0].alarm)
      |=> g_axis[0].err_q[7])
      else $error("cause on the read edge was lost");

   a_evt_read_clear: assert property (
      (CMD.valid && CMD.axis == 2'h3 && CMD.code == CMD_RD_EVT && EVT_SRC[3] == '0)
      |=> (g_axis[3].evt_q == '0) && RD_VALID)
      else $error("event cause not cleared by read");

   a_stop_read_clear: assert property (
      (MSTS_RD[2] && !STOP_DONE[2]) |=> !g_axis[2].seni_q)
      else $error("stop cause not cleared by status read");

   a_unmask_low: assert property (
      ((|pend) && !INT_MASK) |=> !INT_N)
      else $error("pending cause with mask off left interrupt high");

   a_axis_indep: assert property (
      ((ERR_SRC[3] == '0) && !(CMD.valid && CMD.axis == 2'h3)) |=> $stable(g_axis[3].err_q))
      else $error("error cause changed without its own axis acting");

   c_err_int: cover property (ERR_SRC[0] != '0 ##2 !INT_N);
   c_evt_read: cover property (g_axis[1].evt_q != '0 ##1 RD_VALID);
   c_stop_int: cover property (STOP_DONE[2] && STOP_INT_EN[2] ##1 g_axis[2].seni_q);
   c_mask_off: cover property (INT_MASK && (|pend) ##1 !INT_MASK ##1 !INT_N);
   c_stop_held: cover property (STOP_DONE[1] && STOP_SUPPRESS[1] && PRE_PENDING[1] ##1 !g_axis[1].seni_q);

endmodule // aic_top
`default_nettype wire

// ==== tb/aic_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module aic_host
   import aic_pkg::*;
(
   // clock
   input  wire logic     CLK,
   // command toward the block
   output var  aic_cmd_t CMD
);
   initial CMD = '0;

   // ****************************************
   // command issue
   // ****************************************
   // valid stands for exactly one edge, as a cpu write strobe would
   task automatic send(input logic [1:0] ax, input logic [CODE_W-1:0] c,
                       input logic [DATA_W-1:0] d);
      @(posedge CLK);
      CMD <= '{valid: 1'h1, axis: ax, code: c, data: d};
      @(posedge CLK);
      CMD <= '0;
   endtask
endmodule // aic_host
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench
   import aic_pkg::*;
();
   logic                        CLK, RST_B, INT_MASK, RD_VALID, INT_N;
   aic_cmd_t                    CMD;
   logic [DATA_W-1:0]           RD_DATA;
   aic_err_src_t [NUM_AXES-1:0] ERR_SRC;
   aic_evt_src_t [NUM_AXES-1:0] EVT_SRC;
   aic_msts_t [NUM_AXES-1:0]    MSTS;
   logic [NUM_AXES-1:0]         STOP_DONE, PRE_PENDING, START_CMD_RUN, MSTS_RD;
   logic [NUM_AXES-1:0]         STOP_INT_EN, STOP_SUPPRESS, STOP_REQ;
   logic [ERR_W-1:0]            err_m [NUM_AXES];
   logic [EVT_W-1:0]            evt_m [NUM_AXES];
   logic [EN_W-1:0]             en_m [NUM_AXES];
   logic [NUM_AXES-1:0]         stop_m;
   int                          mismatches, samples_checked;

   aic_host aic_host_i (.CLK(CLK), .CMD(CMD));
   aic_top aic_top_i (.CLK(CLK), .RST_B(RST_B), .CMD(CMD), .RD_DATA(RD_DATA),
      .RD_VALID(RD_VALID), .ERR_SRC(ERR_SRC), .EVT_SRC(EVT_SRC), .STOP_DONE(STOP_DONE),
      .PRE_PENDING(PRE_PENDING), .START_CMD_RUN(START_CMD_RUN), .MSTS_RD(MSTS_RD),
      .STOP_INT_EN(STOP_INT_EN), .STOP_SUPPRESS(STOP_SUPPRESS), .INT_MASK(INT_MASK),
      .MSTS(MSTS), .STOP_REQ(STOP_REQ), .INT_N(INT_N));

   // ****************************************
   // reference model and checks
   // ****************************************
   // enable 17 is shared by both direction changes, so the map is not one to one
   function automatic logic [EVT_W-1:0] gate(input logic [EN_W-1:0] en);
      return {en[18], en[17], en[17:0]};
   endfunction

   function automatic logic int_exp();
      logic p;
      p = 1'h0;
      for (int i = 0; i < NUM_AXES; i++)
         p |= (err_m[i] != '0) || ((evt_m[i] & gate(en_m[i])) != '0) || stop_m[i];
      return !(p && !INT_MASK);
   endfunction

   task automatic chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
      #1;
   endtask

   task automatic rd(input logic [1:0] a, input logic evt);
      aic_host_i.send(a, evt ? CMD_RD_EVT : CMD_RD_ERR, '0);
      #1;
      chk(RD_VALID, 1'h1);
      chk(RD_DATA, evt ? DATA_W'(evt_m[a]) : DATA_W'(err_m[a]));
      if (evt) evt_m[a] = '0;
      else err_m[a] = '0;
   endtask

   task automatic pulse(input logic [1:0] a, input logic [ERR_W-1:0] e,
                        input logic [EVT_W-1:0] v);
      @(posedge CLK);
      ERR_SRC[a] <= e;
      EVT_SRC[a] <= v;
      @(posedge CLK);
      ERR_SRC <= '0;
      EVT_SRC <= '0;
      err_m[a] |= e & ~ERR_UNDEF_MASK;
      evt_m[a] |= v & gate(en_m[a]);
      #1;
      chk(STOP_REQ[a], |(e & ~ERR_UNDEF_MASK & ~ERR_NOSTOP_MASK));
      tick(1);
      chk(INT_N, int_exp());
      chk(MSTS[a].err_int, err_m[a] != '0);
      chk(MSTS[a].evt_int, evt_m[a] != '0);
   endtask

   // ****************************************
   // clock, watchdog and sequence
   // ****************************************
   initial begin
      CLK = 1'h0;
      forever #50 CLK = ~CLK;
   end

   // the sequence needs well under 1000 cycles
   initial begin
      #200000;
      mismatches++;
      end_of_test();
   end

   initial begin
      logic [1:0]        a;
      logic [DATA_W-1:0] d;
      RST_B = 1'h0;
      INT_MASK = 1'h0;
      ERR_SRC = '0;
      EVT_SRC = '0;
      STOP_DONE = '0;
      PRE_PENDING = '0;
      START_CMD_RUN = '0;
      MSTS_RD = '0;
      STOP_INT_EN = '0;
      STOP_SUPPRESS = '0;
      stop_m = '0;
      mismatches = 0;
      samples_checked = 0;
      for (int i = 0; i < NUM_AXES; i++) begin
         err_m[i] = '0;
         evt_m[i] = '0;
         en_m[i] = '0;
      end
      void'($urandom(3));
      repeat (5) @(posedge CLK);
      RST_B <= 1'h1;
      tick(1);
      chk(INT_N, 1'h1);
      chk(RD_VALID, 1'h0);
      // random enables and causes; odd passes carry events only
      for (int k = 0; k < 16; k++) begin
         a = 2'(k);
         d = DATA_W'($urandom) & 32'h0007FFFF;
         aic_host_i.send(a, CMD_WR_EN, d);
         en_m[a] = EN_W'(d);
         pulse(a, k[0] ? '0 : ERR_W'($urandom), EVT_W'($urandom));
         if (k % 3 == 0) rd(a, 1'h0);
         if (k % 3 == 1) rd(a, 1'h1);
      end
      // mask keeps the pin high while status still records
      pulse(2'h1, 18'h00880, '0);
      @(posedge CLK);
      INT_MASK <= 1'h1;
      tick(2);
      chk(INT_N, int_exp());
      pulse(2'h2, 18'h00001, '0);
      @(posedge CLK);
      INT_MASK <= 1'h0;
      tick(2);
      chk(INT_N, int_exp());
      // a cause landing on the read edge survives the clear
      d = DATA_W'(err_m[0]);
      fork
         aic_host_i.send(2'h0, CMD_RD_ERR, '0);
         pulse(2'h0, 18'h00080, '0);
      join
      chk(RD_DATA, d);
      err_m[0] = 18'h00080;
      rd(2'h0, 1'h0);
      // stop interrupt over every suppress, start and pending mix, then disabled
      for (int k = 0; k < 9; k++) begin
         a = 2'(k);
         @(posedge CLK);
         STOP_INT_EN[a] <= (k != 8);
         STOP_SUPPRESS[a] <= k[0];
         START_CMD_RUN[a] <= k[1];
         PRE_PENDING[a] <= k[2];
         STOP_DONE[a] <= 1'h1;
         @(posedge CLK);
         STOP_DONE <= '0;
         stop_m[a] = (k != 8) && (!k[0] || k[1] || !k[2]);
         tick(1);
         chk(MSTS[a].stop_int, stop_m[a]);
         chk(INT_N, int_exp());
         @(posedge CLK);
         MSTS_RD[a] <= 1'h1;
         @(posedge CLK);
         MSTS_RD <= '0;
         stop_m[a] = 1'h0;
      end
      // clearing axis by axis; the pin holds until the last cause goes
      for (int i = 0; i < NUM_AXES; i++) begin
         rd(2'(i), 1'h0);
         rd(2'(i), 1'h1);
         tick(1);
         chk(INT_N, int_exp());
      end
      chk(INT_N, 1'h1);
      end_of_test();
   end
endmodule // testbench
`default_nettype wire
